// [lcdi_fifo.sv]
`default_nettype none
`default_nettype wire

// [lcdi_master.sv]
`default_nettype none
module lcdi_master (
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_pull_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int hp = 24;
	// Clock stands high and data is released between frames
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	task automatic bit_x(input logic b, output logic s);
		#(hp / 2) sda_pull_o = !b;
		#(hp / 2) scl_o = 1'b1;
		#(hp / 2) s = sda_i;
		#(hp / 2) scl_o = 1'b0;
	endtask
	task automatic start();
		sda_pull_o = 1'b0;
		scl_o = 1'b1;
		#hp sda_pull_o = 1'b1;
		#hp scl_o = 1'b0;
	endtask
	task automatic stop();
		#(hp / 2) sda_pull_o = 1'b1;
		#(hp / 2) scl_o = 1'b1;
		#hp sda_pull_o = 1'b0;
		#hp;
	endtask
	task automatic wr(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(b[i], s);
		bit_x(1'b1, s);
		ack = !s;
	endtask
	task automatic rd(output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, s);
			d[i] = s;
		end
		bit_x(1'b1, s);
	endtask
endmodule
`default_nettype wire

// [lcdi_pkg.sv]
`default_nettype none
package lcdi_pkg;
	// ----------------------------------------
	// Bus addressing
	// ----------------------------------------
	localparam logic [6:0] ADDR_BASE = 7'h3c;
	localparam logic [3:0] ID_CODE = 4'h5; // Arbitrary identity value
	// ----------------------------------------
	// Command bytes
	// ----------------------------------------
	localparam logic [7:0] CMD_IND_MASK = 8'hfe;
	localparam logic [7:0] CMD_IND = 8'hac;
	localparam logic [7:0] CMD_NOP = 8'he3;
	localparam logic [7:0] CMD_DISP_OFF = 8'hae;
	localparam logic [7:0] CMD_DISP_ON = 8'haf;
	localparam logic [7:0] CMD_ENT_ON = 8'ha5;
	localparam logic [7:0] CMD_ENT_OFF = 8'ha4;
	localparam logic [7:0] CMD_SEG_MASK = 8'hfe;
	localparam logic [7:0] CMD_SEG = 8'ha0;
	localparam logic [7:0] CMD_MUX = 8'ha8;
	localparam logic [7:0] CMD_BIAS_OSC = 8'ha9;
	localparam logic [7:0] CMD_QBIAS_MASK = 8'hfe;
	localparam logic [7:0] CMD_QBIAS = 8'haa;
	localparam logic [7:0] CMD_PHASE = 8'hd4;
	localparam logic [7:0] CMD_OFFSET = 8'hd3;
	localparam logic [7:0] CMD_BGAP = 8'hd6;
	localparam logic [7:0] CMD_SWRST = 8'he2;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [6:0] MUX_RST = 7'h41;
	localparam logic [6:0] MUX_ADD = 7'h02;
	localparam logic [2:0] OSC_RST = 3'h3;
	localparam logic [1:0] PHASE_RST = 2'h2;
	localparam logic [1:0] BGAP_RST = 2'h3;
	localparam logic [7:0] BYTE_LAST = 8'h80;
	// Initialisation after reset, in ns and cycles
	localparam int INIT_NS = 10000;
	localparam int CLK_NS = 5;
	localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 16;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b011,
		ST_RX = 3'b010,
		ST_RACK = 3'b110,
		ST_TX = 3'b111,
		ST_TACK = 3'b101
	} lcdi_state_t;
	typedef enum logic [1:0] {
		EX_NONE = 2'b00,
		EX_CMD = 2'b01,
		EX_ARG = 2'b11
	} lcdi_ex_t;
endpackage
`default_nettype wire

// [lcdi_port.sv]
`default_nettype none
// Operation
// (R1) Indicator on takes a mode byte
// (R2) Mode byte low bits pick indicator mode
// (R3) No-operation byte changes nothing
// (R4) Host never sends test-mode bytes
// (R5) Display off then entire on: power save
// (R6) Mux ratio is field plus two
// (R7) Bits 7:5 trim oscillator, default 011
// (R8) Quarter-bias bit overrides other bias
// (R9) Frame phase field bits 5:4
// (R10) Six-bit display offset, reset zero
// (R11) Band-gap period code, reset 800 ms
// (R12) Host sends only defined commands
// (R13) Start: SDA falls while SCL high
// (R14) Address pair chosen by select pin
// (R15) Acknowledge address and each written byte; a data byte refused by the full queue is not acknowledged
// (R16) Control byte carries continuation, select
// (R17) Continuation zero: rest is payload
// (R18) Data bytes go to RAM, column increments
// (R19) Stop: SDA rises while SCL high
// (R20) SDA changes only while SCL low
// (R21) Read returns one status byte
// (R22) Status: busy, map, off, init, id
module lcdi_port (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic addr_select_pin_i,
	input wire logic busy_i,
	output logic [7:0] ram_data_o,
	output logic ram_valid_o,
	input wire logic ram_ready_i,
	output logic [7:0] column_o,
	output logic [1:0] ind_mode_o,
	output logic power_save_o,
	output logic sleep_o,
	output logic display_off_flag_o,
	output logic seg_map_flag_o,
	output logic entire_on_o,
	output logic [6:0] mux_ratio_o,
	output logic [1:0] bias_code_o,
	output logic [2:0] temp_coeff_o,
	output logic [2:0] osc_trim_o,
	output logic quarter_bias_o,
	output logic [1:0] static_icon_drive_o,
	output logic [5:0] offset_o,
	output logic [1:0] bgap_code_o
);
	import lcdi_pkg::*;
	// ----------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------
	logic [1:0] scl_s;
	logic [1:0] sda_s;
	logic scl_d;
	logic sda_d;
	logic [1:0] sel_s;
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			sel_s <= 2'h0;
		end else begin
			scl_s <= {scl_s[0], scl_i};
			sda_s <= {sda_s[0], sda_i};
			scl_d <= scl_s[1];
			sda_d <= sda_s[1];
			sel_s <= {sel_s[0], addr_select_pin_i};
		end
	end
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	assign scl_rise = scl_s[1] && !scl_d;
	assign scl_fall = !scl_s[1] && scl_d;
	assign start_cond = scl_s[1] && scl_d && sda_d && !sda_s[1]; // (R13)
	assign stop_cond = scl_s[1] && scl_d && !sda_d && sda_s[1]; // (R19)
	// ----------------------------------------
	// Bit engine
	// ----------------------------------------
	lcdi_state_t state;
	logic [7:0] shreg;
	logic [7:0] txreg;
	logic [2:0] bitcnt;
	logic ctrl_phase;
	logic cont_bit;
	logic dc_bit;
	logic byte_done;
	logic [7:0] rx_byte;
	logic [7:0] status_byte;
	logic addr_hit;
	logic fifo_ready;
	logic rx_taken;
	assign rx_byte = {shreg[6:0], sda_s[1]};
	assign addr_hit = rx_byte[7:1] == (ADDR_BASE | {6'h00, sel_s[1]}); // (R14)
	// Byte handled on the eighth rising edge of SCL
	assign byte_done = scl_rise && bitcnt == 3'h7;
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			state <= ST_IDLE;
			bitcnt <= 3'h0;
			shreg <= 8'h00;
			txreg <= 8'h00;
			ctrl_phase <= 1'b1;
			cont_bit <= 1'b0;
			dc_bit <= 1'b0;
			rx_taken <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (start_cond) begin
			state <= ST_ADDR;
			bitcnt <= 3'h0;
			sda_oe_o <= 1'b0;
		end else if (stop_cond) begin
			state <= ST_IDLE;
			sda_oe_o <= 1'b0;
		end else begin
			unique case (state)
			ST_IDLE: begin
				sda_oe_o <= 1'b0;
			end
			ST_ADDR: begin
				if (scl_rise) begin
					shreg <= rx_byte;
					bitcnt <= bitcnt + 3'h1;
				end
				if (byte_done) begin
					state <= addr_hit ? ST_AACK : ST_IDLE;
					ctrl_phase <= 1'b1;
				end
			end
			ST_AACK: begin
				// Drive only after SCL falls so SDA changes while SCL is low (R20)
				if (scl_fall && !sda_oe_o) begin
					sda_oe_o <= 1'b1; // (R15)
				end else if (scl_fall) begin
					sda_oe_o <= 1'b0;
					bitcnt <= 3'h0;
					if (shreg[0]) begin
						state <= ST_TX; // (R21)
						txreg <= status_byte;
						sda_oe_o <= !status_byte[7];
					end else begin
						state <= ST_RX;
					end
				end
			end
			ST_RX: begin
				if (scl_rise) begin
					shreg <= rx_byte;
					bitcnt <= bitcnt + 3'h1;
				end
				if (byte_done) begin
					state <= ST_RACK;
					rx_taken <= ctrl_phase || !dc_bit || fifo_ready;
					if (ctrl_phase) begin
						cont_bit <= rx_byte[7]; // (R16)
						dc_bit <= rx_byte[6];
						ctrl_phase <= 1'b0;
					end else begin
						ctrl_phase <= cont_bit; // (R17)
					end
				end
			end
			ST_RACK: begin
				// A data byte the full queue refused is not acknowledged
				if (scl_fall && bitcnt == 3'h0) begin
					sda_oe_o <= rx_taken; // (R15)
					bitcnt <= 3'h1;
				end else if (scl_fall) begin
					sda_oe_o <= 1'b0;
					bitcnt <= 3'h0;
					state <= ST_RX;
				end
			end
			ST_TX: begin
				if (scl_fall) begin
					txreg <= {txreg[6:0], 1'b0};
					bitcnt <= bitcnt + 3'h1;
					sda_oe_o <= bitcnt != 3'h7 && !txreg[6]; // (R20)
					if (bitcnt == 3'h7) begin
						state <= ST_TACK;
					end
				end
			end
			ST_TACK: begin
				// One status byte per read; then wait for stop
				if (scl_fall) begin
					state <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
	assign sda_o = 1'b0;
	// ----------------------------------------
	// Byte dispatch
	// ----------------------------------------
	logic pay_strobe;
	logic is_data;
	assign pay_strobe = state == ST_RX && byte_done && !ctrl_phase;
	assign is_data = pay_strobe && dc_bit;
	lcdi_fifo #(
		.W(FIFO_W),
		.D(FIFO_D)
	) i_lcdi_fifo (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.in_data_i(rx_byte),
		.in_valid_i(is_data),
		.in_ready_o(fifo_ready),
		.out_data_o(ram_data_o),
		.out_valid_o(ram_valid_o),
		.out_ready_i(ram_ready_i)
	);
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			column_o <= 8'h00;
		end else if (ram_valid_o && ram_ready_i) begin
			column_o <= column_o + 8'h01; // (R18)
		end
	end
	// ----------------------------------------
	// Command decoder
	// ----------------------------------------
	logic cmd_strobe;
	logic [7:0] pend_cmd;
	lcdi_ex_t ex;
	logic prev_off;
	logic [$clog2(INIT_CYC+1)-1:0] init_cnt;
	assign cmd_strobe = pay_strobe && !dc_bit;
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			ex <= EX_NONE;
			pend_cmd <= 8'h00;
			prev_off <= 1'b0;
			ind_mode_o <= 2'h0;
			power_save_o <= 1'b0;
			display_off_flag_o <= 1'b1;
			seg_map_flag_o <= 1'b1;
			entire_on_o <= 1'b0;
			mux_ratio_o <= MUX_RST;
			bias_code_o <= 2'h0;
			temp_coeff_o <= 3'h0;
			osc_trim_o <= OSC_RST;
			quarter_bias_o <= 1'b0;
			static_icon_drive_o <= PHASE_RST;
			offset_o <= 6'h00;
			bgap_code_o <= BGAP_RST;
			init_cnt <= '0;
		end else begin
			if (init_cnt != INIT_CYC[$bits(init_cnt)-1:0]) begin
				init_cnt <= init_cnt + 1'b1;
			end
			if (cmd_strobe && ex == EX_ARG) begin
				ex <= EX_NONE;
				unique case (pend_cmd)
				CMD_MUX: mux_ratio_o <= {1'b0, rx_byte[5:0]} + MUX_ADD; // (R6)
				CMD_BIAS_OSC: begin
					osc_trim_o <= rx_byte[7:5]; // (R7)
					temp_coeff_o <= rx_byte[4:2];
					bias_code_o <= rx_byte[1:0];
				end
				CMD_PHASE: static_icon_drive_o <= rx_byte[5:4]; // (R9)
				CMD_OFFSET: offset_o <= rx_byte[5:0]; // (R10)
				CMD_BGAP: bgap_code_o <= rx_byte[1:0]; // (R11)
				default: ind_mode_o <= rx_byte[1:0]; // (R2)
				endcase
			end else if (cmd_strobe) begin
				pend_cmd <= rx_byte;
				// A no-operation byte must not break the save pair
				if (rx_byte != CMD_NOP) begin
					prev_off <= rx_byte == CMD_DISP_OFF; // (R3)
				end
				if (rx_byte == CMD_ENT_ON && prev_off) begin
					power_save_o <= 1'b1; // (R5)
				end else if (rx_byte != CMD_NOP) begin // (R3)
					power_save_o <= 1'b0;
				end
				if ((rx_byte & CMD_IND_MASK) == CMD_IND) begin
					// Off is single byte, on waits for mode
					if (rx_byte[0]) begin
						ex <= EX_ARG; // (R1)
					end else begin
						ind_mode_o <= 2'h0; // (R1)
					end
				end else if (rx_byte == CMD_MUX || rx_byte == CMD_BIAS_OSC ||
					rx_byte == CMD_PHASE || rx_byte == CMD_OFFSET ||
					rx_byte == CMD_BGAP) begin
					ex <= EX_ARG;
				end else if ((rx_byte & CMD_QBIAS_MASK) == CMD_QBIAS) begin
					quarter_bias_o <= rx_byte[0]; // (R8)
				end else if (rx_byte == CMD_DISP_OFF) begin
					display_off_flag_o <= 1'b1;
				end else if (rx_byte == CMD_DISP_ON) begin
					display_off_flag_o <= 1'b0;
				end else if (rx_byte == CMD_ENT_ON) begin
					entire_on_o <= 1'b1;
				end else if (rx_byte == CMD_ENT_OFF) begin
					entire_on_o <= 1'b0;
				end else if ((rx_byte & CMD_SEG_MASK) == CMD_SEG) begin
					seg_map_flag_o <= !rx_byte[0];
				end else if (rx_byte == CMD_SWRST) begin
					ind_mode_o <= 2'h0;
					init_cnt <= '0;
				end
			end
		end
	end
	// Sleep when indicator off, standby otherwise
	assign sleep_o = power_save_o && ind_mode_o == 2'h0;
	logic init_pending_flag;
	assign init_pending_flag = init_cnt != INIT_CYC[$bits(init_cnt)-1:0];
	assign status_byte = {busy_i || init_pending_flag, seg_map_flag_o,
		display_off_flag_o, init_pending_flag, ID_CODE}; // (R22)
endmodule
module lcdi_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic [W-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [W-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wp;
	logic [AW:0] rp;
	logic [AW:0] cnt;
	assign cnt = wp - rp;
	assign in_ready_o = cnt != (AW+1)'(D);
	assign out_valid_o = cnt != '0;
	assign out_data_o = mem[rp[AW-1:0]];
	always_ff @(posedge ref_clk_i) begin
		if (in_valid_i && in_ready_o) begin
			mem[wp[AW-1:0]] <= in_data_i;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			wp <= '0;
			rp <= '0;
		end else begin
			if (in_valid_i && in_ready_o) begin
				wp <= wp + 1'b1;
			end
			if (out_valid_o && out_ready_i) begin
				rp <= rp + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [lcdi_port_assertions.sv]
`default_nettype none
module lcdi_port_checker (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic [7:0] ram_data_o,
	input wire logic ram_valid_o,
	input wire logic ram_ready_i,
	input wire logic [7:0] column_o,
	input wire logic [1:0] ind_mode_o,
	input wire logic power_save_o,
	input wire logic sleep_o,
	input wire logic display_off_flag_o,
	input wire logic entire_on_o,
	input wire logic [6:0] mux_ratio_o,
	input wire logic [2:0] osc_trim_o,
	input wire logic quarter_bias_o,
	input wire logic [1:0] static_icon_drive_o,
	input wire logic [5:0] offset_o,
	input wire logic [1:0] bgap_code_o
);
	import lcdi_pkg::*;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	property p_rst;
		$rose(nrst_i) |-> mux_ratio_o == MUX_RST && osc_trim_o == OSC_RST
			&& static_icon_drive_o == PHASE_RST && offset_o == 6'h00
			&& bgap_code_o == BGAP_RST && !quarter_bias_o;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset value");
	property p_mux;
		mux_ratio_o >= 7'h02 && mux_ratio_o <= 7'h41;
	endproperty
	a_mux: assert property (p_mux) else $error("ratio out of range");
	// Answers move only while the clock line is low
	property p_move;
		$changed(sda_oe_o) |-> !scl_i;
	endproperty
	a_move: assert property (p_move) else $error("sda moved high");
	property p_ack;
		$rose(scl_i) && sda_oe_o |-> sda_oe_o [*5];
	endproperty
	a_ack: assert property (p_ack) else $error("ack dropped");
	property p_od;
		sda_oe_o |-> sda_o == 1'b0;
	endproperty
	a_od: assert property (p_od) else $error("sda not low");
	property p_col;
		ram_valid_o && ram_ready_i |=> column_o == $past(column_o) + 8'h01;
	endproperty
	a_col: assert property (p_col) else $error("column step");
	property p_hold;
		ram_valid_o && !ram_ready_i |=> ram_valid_o && $stable(ram_data_o);
	endproperty
	a_hold: assert property (p_hold) else $error("data not held");
	property p_ps;
		power_save_o |-> display_off_flag_o && entire_on_o;
	endproperty
	a_ps: assert property (p_ps) else $error("save without pair");
	property p_sleep;
		power_save_o |-> sleep_o == (ind_mode_o == 2'h0);
	endproperty
	a_sleep: assert property (p_sleep) else $error("wrong save kind");
	c_ack: cover property ($rose(sda_oe_o));
	c_stby: cover property (power_save_o && !sleep_o);
	c_pop: cover property (ram_valid_o && ram_ready_i);
endmodule
bind lcdi_port lcdi_port_checker i_lcdi_port_checker (.ref_clk_i, .nrst_i,
	.scl_i, .sda_o, .sda_oe_o, .ram_data_o, .ram_valid_o, .ram_ready_i,
	.column_o, .ind_mode_o, .power_save_o, .sleep_o, .display_off_flag_o,
	.entire_on_o, .mux_ratio_o, .osc_trim_o, .quarter_bias_o,
	.static_icon_drive_o, .offset_o, .bgap_code_o);
`default_nettype wire

// [lcdi_port_bench.sv]
`default_nettype none
module lcdi_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import lcdi_pkg::*;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic sel = 1'b0;
	logic busy = 1'b0;
	logic rdy = 1'b0;
	logic scl, pull, oe, rvalid, ps, sl, doff, smap, ent, qb, a;
	logic [7:0] rdata, col, d;
	logic [1:0] ind, icon, bgap, bias;
	logic [2:0] osc, tc;
	logic [6:0] mux;
	logic [5:0] ofs;
	int n_fail = 0;
	int samples_checked = 0;
	// Only defined commands are sent
	logic [7:0] seq [16] = '{CMD_MUX, 8'h0f, CMD_BIAS_OSC, 8'hf1,
		CMD_QBIAS | 8'h01, CMD_PHASE, 8'h30, CMD_OFFSET, 8'h05, CMD_BGAP,
		8'h3c, CMD_IND, CMD_NOP, CMD_IND | 8'h01, 8'h02, CMD_DISP_OFF};
	wire logic sda = !(pull || oe);
	always #2.5 ref_clk_i = !ref_clk_i;
	lcdi_master i_lcdi_master (.sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
	lcdi_port i_lcdi_port (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe),
		.addr_select_pin_i(sel), .busy_i(busy), .ram_data_o(rdata),
		.ram_valid_o(rvalid), .ram_ready_i(rdy), .column_o(col),
		.ind_mode_o(ind), .power_save_o(ps), .sleep_o(sl),
		.display_off_flag_o(doff), .seg_map_flag_o(smap), .entire_on_o(ent),
		.mux_ratio_o(mux), .bias_code_o(bias), .temp_coeff_o(tc),
		.osc_trim_o(osc), .quarter_bias_o(qb), .static_icon_drive_o(icon),
		.offset_o(ofs),
		.bgap_code_o(bgap));
	task automatic chk(input logic [7:0] s, e, input string n);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] b, input logic e);
		i_lcdi_master.wr(b, a);
		chk({7'h0, a}, {7'h0, e}, "ack");
	endtask
	task automatic open_wr();
		i_lcdi_master.start();
		wr({ADDR_BASE, 1'b0}, 1'b1);
	endtask
	task automatic rd_status(input logic [7:0] e);
		i_lcdi_master.start();
		wr({ADDR_BASE | 7'(sel), 1'b1}, 1'b1);
		i_lcdi_master.rd(d);
		i_lcdi_master.stop();
		chk(d, e, "status");
	endtask
	initial begin
		repeat (12) @(negedge ref_clk_i);
		nrst_i = 1'b1;
		chk({1'b0, mux}, {1'b0, MUX_RST}, "mux");
		chk({osc, qb, icon, bgap}, 8'h6b, "regs");
		chk({2'h0, ofs}, 8'h00, "offset");
		chk({3'h0, tc, bias}, 8'h00, "bias");
		// Pending initialisation also reads as busy
		rd_status({4'hf, ID_CODE});
		i_lcdi_master.start();
		wr({ADDR_BASE ^ 7'h02, 1'b0}, 1'b0);
		i_lcdi_master.stop();
		$display("reset and address done");
		open_wr();
		foreach (seq[i]) begin
			wr(8'h80, 1'b1);
			wr(seq[i], 1'b1);
		end
		wr(8'h80, 1'b1);
		wr(CMD_NOP, 1'b1);
		wr(8'h80, 1'b1);
		wr(CMD_ENT_ON, 1'b1);
		i_lcdi_master.stop();
		chk({1'b0, mux}, 8'h11, "mux");
		chk({osc, qb, icon, bgap}, 8'hfc, "regs");
		chk({3'h0, tc, bias}, 8'h11, "bias");
		chk({ofs, ind}, 8'h16, "offset");
		chk({ps, sl, doff, ent, 4'h0}, 8'hb0, "save");
		$display("command test done");
		open_wr();
		wr(8'h00, 1'b1);
		wr(CMD_DISP_ON, 1'b1);
		wr(CMD_SEG | 8'h01, 1'b1);
		i_lcdi_master.stop();
		chk({5'h0, ps, doff, smap}, 8'h00, "mode");
		$display("stream test done");
		open_wr();
		wr(8'h40, 1'b1);
		for (int i = 0; i < 17; i++) wr(8'(i + 8'h30), i < 16);
		i_lcdi_master.stop();
		@(negedge ref_clk_i);
		rdy = 1'b1;
		for (int i = 0; i < 16; i++) begin
			chk({7'h0, rvalid}, 8'h01, "valid");
			chk(rdata, 8'(i + 8'h30), "data");
			@(negedge ref_clk_i);
		end
		chk({7'h0, rvalid}, 8'h00, "empty");
		chk(col, 8'h10, "column");
		$display("data test done");
		open_wr();
		wr(8'h00, 1'b1);
		wr(CMD_SWRST, 1'b1);
		i_lcdi_master.stop();
		chk({6'h0, ind}, 8'h00, "indicator");
		sel = 1'b1;
		busy = 1'b1;
		rd_status({4'h9, ID_CODE});
		$display("status test done");
		finish_test();
	end
	// Whole run needs about a tenth of this
	initial begin
		#300us;
		n_fail++;
		finish_test();
	end
endmodule
`default_nettype wire
